/* File: design/compact_shift_addsub_decoder.v */
// Decode and execute of compact shift and add/subtract instructions
`include "compact_decoder_defines.vh"
`default_nettype none

module compact_shift_addsub_decoder
(
    // Clock and reset
    input  wire                 clk_sys,
    input  wire                 rst,
    input  wire                 clk_en,
    // From fetch stage
    input  wire                 instr_valid,
    input  wire [`INSTR_W-1:0]  instr,
    // Register file read data, addressed by rd_addr_*_r
    input  wire [`WORD_W-1:0]   rd_data_a,
    input  wire [`WORD_W-1:0]   rd_data_b,
    // Current status flags
    input  wire [`FLAGS_W-1:0]  program_status_word,
    // Register file read addresses
    output reg  [`REGNUM_W-1:0] rd_addr_a_r,
    output reg  [`REGNUM_W-1:0] rd_addr_b_r,
    // Register file write
    output reg                  wr_en_r,
    output reg  [`REGNUM_W-1:0] wr_addr_r,
    output reg  [`WORD_W-1:0]   wr_data_r,
    // Status flag update
    output reg                  flags_wr_r,
    output reg  [`FLAGS_W-1:0]  flags_r,
    // Handshake to fetch and execute
    output reg                  busy_r,
    output reg                  unsupported_r
);

    // *****************************************************************
    // States
    // *****************************************************************
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_EXEC = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    // *****************************************************************
    // Helpers
    // *****************************************************************
    // Widen a 3-bit field to a register number: always 0..7
    function [`REGNUM_W-1:0] low_reg;
        input [`LOWREG_W-1:0] f;
        begin
            low_reg = {1'b0, f};
        end
    endfunction

    function [`FLAGS_W-1:0] nz_flags;
        input [`WORD_W-1:0] r;
        input               c;
        input               v;
        begin
            nz_flags = {r[`WORD_W-1], r == {`WORD_W{1'b0}}, c, v};
        end
    endfunction

    // *****************************************************************
    // Decode of the incoming word
    // *****************************************************************
    // Opcode 11 under a zero top field belongs to add/subtract
    wire is_shift  = (instr[`FMT_TOP_HI:`FMT_TOP_LO] == `FMT_SHIFT_TOP) &&
                     (instr[`SH_OP_HI:`SH_OP_LO] != `OP_RESV);
    wire is_addsub = (instr[`FMT_ADDSUB_HI:`FMT_ADDSUB_LO] ==
                      `FMT_ADDSUB_CODE);

    // Sequencer state and the fields held for execute
    reg [2:0]            fsm_r;
    reg [2:0]            fsm_nxt;
    reg                  kind_shift_r;
    reg [1:0]            sh_op_r;
    reg [`SHAMT_W-1:0]   shift_amount_imm_r;
    reg                  imm_sel_r;
    reg                  sub_op_r;
    reg [`LOWREG_W-1:0]  small_imm_r;
    reg [`LOWREG_W-1:0]  dst_r;
    reg [1:0]            cyc_r;

    // *****************************************************************
    // Execute
    // *****************************************************************
    wire [`WORD_W-1:0] sh_res;
    wire               sh_c;

    shift_unit u_shift
    (
        .operand   (rd_data_a),
        .amount    (shift_amount_imm_r),
        .kind      (sh_op_r),
        .carry_in  (program_status_word[`FLAG_C]),
        .result    (sh_res),
        .carry_out (sh_c)
    );

    // Second operand: register or zero-extended immediate
    wire [`WORD_W-1:0] opnd_b = imm_sel_r ?
        {{(`WORD_W-`LOWREG_W){1'b0}}, small_imm_r} : rd_data_b;

    // Subtract as a + ~b + 1, so carry means no borrow
    wire [`WORD_W-1:0] b_eff = sub_op_r ? ~opnd_b : opnd_b;
    wire [`WORD_W:0]   sum   = {1'b0, rd_data_a} + {1'b0, b_eff} +
                               {{`WORD_W{1'b0}}, sub_op_r};
    wire               ovf   = (rd_data_a[`WORD_W-1] == b_eff[`WORD_W-1]) &&
                               (sum[`WORD_W-1] != rd_data_a[`WORD_W-1]);

    wire [`WORD_W-1:0] res   = kind_shift_r ? sh_res : sum[`WORD_W-1:0];
    wire [`FLAGS_W-1:0] fl   = kind_shift_r ?
        nz_flags(sh_res, sh_c, program_status_word[`FLAG_V]) :
        nz_flags(sum[`WORD_W-1:0], sum[`WORD_W], ovf);

    // *****************************************************************
    // Sequencer
    // *****************************************************************
    // One cycle to present read addresses, one to execute, like the
    // full-width data-processing form; nothing else is ever accepted
    always @*
    begin
        fsm_nxt = fsm_r;
        case (fsm_r)
            ST_IDLE:
                if (instr_valid && (is_shift || is_addsub))
                    fsm_nxt = ST_EXEC;
            ST_EXEC:
                if (cyc_r == `DATA_OP_CYCLES)
                    fsm_nxt = ST_DONE;
            ST_DONE:
                fsm_nxt = ST_IDLE;
            default:
                fsm_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            fsm_r              <= ST_IDLE;
            kind_shift_r       <= 1'b0;
            sh_op_r            <= `OP_LSL;
            shift_amount_imm_r <= {`SHAMT_W{1'b0}};
            imm_sel_r          <= 1'b0;
            sub_op_r           <= 1'b0;
            small_imm_r        <= {`LOWREG_W{1'b0}};
            dst_r              <= {`LOWREG_W{1'b0}};
            cyc_r              <= 2'h0;
            rd_addr_a_r        <= {`REGNUM_W{1'b0}};
            rd_addr_b_r        <= {`REGNUM_W{1'b0}};
            wr_en_r            <= 1'b0;
            wr_addr_r          <= {`REGNUM_W{1'b0}};
            wr_data_r          <= {`WORD_W{1'b0}};
            flags_wr_r         <= 1'b0;
            flags_r            <= {`FLAGS_W{1'b0}};
            busy_r             <= 1'b0;
            unsupported_r      <= 1'b0;
        end
        else if (clk_en)
        begin
            fsm_r         <= fsm_nxt;
            // Busy mirrors the sequencer so fetch holds its next word
            busy_r        <= (fsm_nxt != ST_IDLE);
            wr_en_r       <= 1'b0;
            flags_wr_r    <= 1'b0;
            unsupported_r <= 1'b0;
            case (fsm_r)
                ST_IDLE:
                begin
                    cyc_r <= 2'h0;
                    if (instr_valid)
                    begin
                        // Other formats go to the full decoder; flag them
                        unsupported_r <= !(is_shift || is_addsub);
                        // Expand fields into an internal full-width op
                        kind_shift_r       <= is_shift;
                        sh_op_r            <= instr[`SH_OP_HI:`SH_OP_LO];
                        shift_amount_imm_r <= instr[`SH_AMT_HI:`SH_AMT_LO];
                        imm_sel_r          <= instr[`AS_IMM_BIT];
                        sub_op_r           <= instr[`AS_OP_BIT];
                        small_imm_r        <= instr[`AS_OPND_HI:`AS_OPND_LO];
                        dst_r              <= instr[`DST_HI:`DST_LO];
                        // Register fields are 3 bits: no high register reachable
                        rd_addr_a_r <= low_reg(instr[`SRC_HI:`SRC_LO]);
                        rd_addr_b_r <= low_reg(instr[`AS_OPND_HI:`AS_OPND_LO]);
                    end
                end
                ST_EXEC:
                begin
                    cyc_r <= cyc_r + 2'h1;
                    if (cyc_r == `DATA_OP_CYCLES)
                    begin
                        wr_en_r    <= 1'b1;
                        wr_addr_r  <= low_reg(dst_r);
                        wr_data_r  <= res;
                        // Both formats set flags; flag-preserving adds and
                        // high-register moves never decode here
                        flags_wr_r <= 1'b1;
                        flags_r    <= fl;
                    end
                end
                default:
                    cyc_r <= 2'h0;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: design/compact_decoder_defines.vh */
// Field positions, opcodes and flag layout for the compact instruction decoder
`ifndef COMPACT_DECODER_DEFINES_VH
`define COMPACT_DECODER_DEFINES_VH

`define INSTR_W         16
`define WORD_W          32
`define LOWREG_W        3
`define REGNUM_W        4
`define SHAMT_W         5
`define FLAGS_W         4

// Format recognition
`define FMT_TOP_HI      15
`define FMT_TOP_LO      13
`define FMT_SHIFT_TOP   3'h0
`define FMT_ADDSUB_HI   15
`define FMT_ADDSUB_LO   11
`define FMT_ADDSUB_CODE 5'h03

// Shift format fields
`define SH_OP_HI        12
`define SH_OP_LO        11
`define SH_AMT_HI       10
`define SH_AMT_LO       6
`define OP_LSL          2'h0
`define OP_LSR          2'h1
`define OP_ASR          2'h2
`define OP_RESV         2'h3

// Add/subtract fields
`define AS_IMM_BIT      10
`define AS_OP_BIT       9
`define AS_OPND_HI      8
`define AS_OPND_LO      6

// Common register fields
`define SRC_HI          5
`define SRC_LO          3
`define DST_HI          2
`define DST_LO          0

// Flag positions in the status word: N Z C V
`define FLAG_N          3
`define FLAG_Z          2
`define FLAG_C          1
`define FLAG_V          0

// Execution cycle count of the full-width equivalents
`define DATA_OP_CYCLES  2'h1

`endif

/* File: design/shift_unit.v */
// Immediate barrel shifter with carry out
`include "compact_decoder_defines.vh"
`default_nettype none

module shift_unit
(
    // Operand
    input  wire [`WORD_W-1:0]  operand,
    input  wire [`SHAMT_W-1:0] amount,
    input  wire [1:0]          kind,
    input  wire                carry_in,
    // Result
    output reg  [`WORD_W-1:0]  result,
    output reg                 carry_out
);

    reg [`WORD_W:0] ext;

    always @*
    begin
        ext       = {`WORD_W+1{1'b0}};
        result    = operand;
        carry_out = carry_in;
        case (kind)
            `OP_LSL:
            begin
                // Amount zero keeps the old carry
                ext    = {1'b0, operand} << amount;
                result = ext[`WORD_W-1:0];
                if (amount != {`SHAMT_W{1'b0}})
                    carry_out = ext[`WORD_W];
            end
            `OP_LSR:
            begin
                // Encoded zero means a shift by 32
                if (amount == {`SHAMT_W{1'b0}})
                begin
                    result    = {`WORD_W{1'b0}};
                    carry_out = operand[`WORD_W-1];
                end
                else
                begin
                    ext       = {operand, 1'b0} >> amount;
                    result    = ext[`WORD_W:1];
                    carry_out = ext[0];
                end
            end
            `OP_ASR:
            begin
                if (amount == {`SHAMT_W{1'b0}})
                begin
                    result    = {`WORD_W{operand[`WORD_W-1]}};
                    carry_out = operand[`WORD_W-1];
                end
                else
                begin
                    ext       = $signed({operand, 1'b0}) >>> amount;
                    result    = ext[`WORD_W:1];
                    carry_out = ext[0];
                end
            end
            default:
            begin
                result    = operand;
                carry_out = carry_in;
            end
        endcase
    end

endmodule

`default_nettype wire

/* File: dv/regfile_model.sv */
// Register file model facing the decoder's read and write ports
`include "compact_decoder_defines.vh"
`default_nettype none
module regfile_model
(
    // Clock
    input  wire logic                 clk_sys,
    // Read side, combinational
    input  wire logic [`REGNUM_W-1:0] rd_addr_a_r,
    input  wire logic [`REGNUM_W-1:0] rd_addr_b_r,
    output logic      [`WORD_W-1:0]   rd_data_a,
    output logic      [`WORD_W-1:0]   rd_data_b,
    // Write side
    input  wire logic                 wr_en_r,
    input  wire logic [`REGNUM_W-1:0] wr_addr_r,
    input  wire logic [`WORD_W-1:0]   wr_data_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`WORD_W-1:0] mem [0:15];
    // Upper half left unknown, so a stray high access shows up
    assign rd_data_a = mem[rd_addr_a_r];
    assign rd_data_b = mem[rd_addr_b_r];
    always @(posedge clk_sys)
        if (wr_en_r)
            mem[wr_addr_r] <= wr_data_r;
endmodule
`default_nettype wire

/* File: dv/compact_decoder_props.sv */
// Port checks for the compact shift and add/subtract decoder
`include "compact_decoder_defines.vh"
`default_nettype none
module compact_decoder_props
(
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 clk_en,
    // Inputs
    input wire logic                 instr_valid,
    input wire logic [`INSTR_W-1:0]  instr,
    input wire logic [`FLAGS_W-1:0]  program_status_word,
    // Outputs
    input wire logic [`REGNUM_W-1:0] rd_addr_a_r,
    input wire logic [`REGNUM_W-1:0] rd_addr_b_r,
    input wire logic                 wr_en_r,
    input wire logic [`REGNUM_W-1:0] wr_addr_r,
    input wire logic                 flags_wr_r,
    input wire logic [`FLAGS_W-1:0]  flags_r,
    input wire logic                 busy_r,
    input wire logic                 unsupported_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic               take;
    logic               fits;
    logic [`INSTR_W-1:0] iq;
    assign take = clk_en && instr_valid && !busy_r;
    // Both formats share a zero top field
    assign fits = instr[15:13] == 3'h0;
    always_ff @(posedge clk_sys)
        if (take && fits)
            iq <= instr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_flags_with_write: assert property (flags_wr_r == wr_en_r)
        else $error("flag strobe apart from write");
    chk_write_latency: assert property (take && fits |-> ##3 wr_en_r)
        else $error("write late");
    chk_busy_span: assert property ($rose(busy_r) |-> busy_r [*3] ##1 !busy_r)
        else $error("busy span wrong");
    chk_refuse_other: assert property (
        take && !fits |=> unsupported_r && !busy_r && !wr_en_r)
        else $error("foreign word not refused");
    chk_write_pulse: assert property (wr_en_r |-> busy_r ##1 !wr_en_r)
        else $error("write not a pulse");
    chk_source_low: assert property (
        take && fits |=> rd_addr_a_r == {1'h0, iq[5:3]})
        else $error("first source wrong");
    chk_second_src: assert property (
        take && instr[15:10] == 6'h06 |=> rd_addr_b_r == {1'h0, iq[8:6]})
        else $error("second source wrong");
    chk_dest_low: assert property (wr_en_r |-> wr_addr_r == {1'h0, iq[2:0]})
        else $error("destination wrong");
    chk_shift_keeps_v: assert property (
        wr_en_r && iq[12:11] != 2'h3 |-> flags_r[0] == program_status_word[0])
        else $error("shift changed overflow");
endmodule
bind compact_shift_addsub_decoder compact_decoder_props compact_decoder_props_i
(
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .clk_en              (clk_en),
    .instr_valid         (instr_valid),
    .instr               (instr),
    .program_status_word (program_status_word),
    .rd_addr_a_r         (rd_addr_a_r),
    .rd_addr_b_r         (rd_addr_b_r),
    .wr_en_r             (wr_en_r),
    .wr_addr_r           (wr_addr_r),
    .flags_wr_r          (flags_wr_r),
    .flags_r             (flags_r),
    .busy_r              (busy_r),
    .unsupported_r       (unsupported_r)
);
`default_nettype wire

/* File: dv/test_compact_shift_addsub_decoder.sv */
// Self-checking bench for the compact shift and add/subtract decoder
`include "compact_decoder_defines.vh"
`default_nettype none
`define CHK(a, b, m) begin check_count++; \
    if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: %s", $time, m); end end
module test_compact_shift_addsub_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, rst = 1, clk_en = 1, instr_valid = 0;
    logic [15:0] instr = 16'h0000, w;
    logic [3:0]  psw = 4'h0;
    wire  [3:0]  ra, rb, wa, fl;
    wire  [31:0] da, db, wd;
    wire         we, fw, busy, unsup;
    logic [31:0] model [0:7];
    integer      seed = 28, fails = 0, check_count = 0, k;
    compact_shift_addsub_decoder compact_shift_addsub_decoder_i (.clk_sys(clk_sys), .rst(rst),
        .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr), .rd_data_a(da), .rd_data_b(db),
        .program_status_word(psw), .rd_addr_a_r(ra), .rd_addr_b_r(rb), .wr_en_r(we),
        .wr_addr_r(wa), .wr_data_r(wd), .flags_wr_r(fw), .flags_r(fl), .busy_r(busy),
        .unsupported_r(unsup));
    regfile_model regfile_model_i (.clk_sys(clk_sys), .rd_addr_a_r(ra), .rd_addr_b_r(rb),
        .rd_data_a(da), .rd_data_b(db), .wr_en_r(we), .wr_addr_r(wa), .wr_data_r(wd));
    always #4 clk_sys = ~clk_sys;
    // Expected {N,Z,C,V,result}; zero count on right shifts means 32
    function automatic logic [35:0] expect_op(input logic [15:0] i, input logic [3:0] f);
        logic [31:0] a, b, r;
        logic [32:0] s;
        logic        c, v;
        integer      m;
        a = model[i[5:3]];
        c = f[1];
        v = f[0];
        m = (i[10:6] == 5'h00 && i[12:11] != 2'h0) ? 32 : i[10:6];
        if (i[12:11] == 2'h0)
        begin
            r = a << m;
            if (m != 0) c = a[32 - m];
        end
        else if (i[12:11] != 2'h3)
        begin
            // Kept apart: a mixed conditional would turn the shift logical
            if (i[12:11] == 2'h1)
                r = a >> m;
            else
                r = $signed(a) >>> m;
            c = a[m - 1];
        end
        else
        begin
            b = i[10] ? {29'h0, i[8:6]} : model[i[8:6]];
            s = i[9] ? {1'h0, a} - {1'h0, b} : {1'h0, a} + {1'h0, b};
            r = s[31:0];
            c = s[32] ^ i[9];
            v = ((a[31] ^ b[31]) == i[9]) && (r[31] != a[31]);
        end
        return {r[31], r == 32'h0, c, v, r};
    endfunction
    // Entered in a rising-edge time step; returns in the edge where busy falls, or in the edge after a refused word is taken
    task automatic run_op(input logic [15:0] i);
        logic [35:0] e;
        integer      n;
        instr_valid <= 1'h1;
        instr <= i;
        psw <= 4'($random(seed));
        @(posedge clk_sys);
        e = expect_op(i, psw);
        if (i[15:13] == 3'h0)
        begin
            instr <= 16'($random(seed));
            n = 0;
            do begin @(posedge clk_sys); #1; n++; end while (we !== 1'h1 && n < 6);
            `CHK(n, 2, "write latency")
            `CHK(wa, {1'h0, i[2:0]}, "destination")
            `CHK(wd, e[31:0], "result")
            `CHK(fl, e[35:32], "flags")
            `CHK(fw, 1'h1, "flag strobe")
            `CHK(unsup, 1'h0, "shift or add refused")
            model[i[2:0]] = e[31:0];
            @(posedge clk_sys);
        end
        else
        begin
            instr_valid <= 1'h0;
            // The refusal pulse stands only until the next edge
            #1;
            `CHK(unsup, 1'h1, "refusal pulse")
            `CHK(busy, 1'h0, "busy on refusal")
            @(posedge clk_sys);
        end
    endtask
    task conclude;
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        for (k = 0; k < 8; k++)
        begin
            model[k] = $random(seed);
            regfile_model_i.mem[k] = model[k];
        end
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        // Back-to-back words; every fourth one keeps its random top field, which is foreign unless it draws zero
        for (k = 0; k < 400; k++)
        begin
            w = 16'($random(seed));
            if (k % 4 != 3) w[15:13] = 3'h0;
            run_op(w);
        end
        // Enable low freezes the sequencer even with a word waiting
        clk_en <= 1'h0;
        instr_valid <= 1'h1;
        instr <= 16'h1800;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK({busy, unsup, we}, 3'h0, "word taken while frozen")
        @(posedge clk_sys);
        clk_en <= 1'h1;
        instr_valid <= 1'h0;
        repeat (4) @(posedge clk_sys);
        conclude;
    end
    initial
    begin
        #60000;
        fails++;
        conclude;
    end
endmodule
`default_nettype wire
